// File: verilog/fpm_top.sv
/*
  fan drive behavior mux: duty registers, per-output behavior select,
  turn-on thresholds, spin-up and the shared output pin choice.
  assumes temperatures arrive as signed whole degrees, synchronous to
  clk_sys, and that tach inputs are already clean and synchronous.
*/
`include "fpm_defines.svh"
`default_nettype none
module fpm_top
  import fpm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire fpm_req_t    reg_req,
  output var  logic [7:0]  reg_rdata_q,
  input  wire logic [7:0]  temp_rem1,
  input  wire logic [7:0]  temp_local,
  input  wire logic [7:0]  temp_rem2,
  input  wire logic [2:0]  tach_in,
  input  wire logic        alert_req,
  output var  logic [2:0]  fan_drive_out_q,
  output var  logic        alert_out_q
);
  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  logic [7:0] duty_q    [3];  // applied duty per output
  logic [7:0] cfg_q     [3];  // behavior select and spare bits
  logic [7:0] freq_q    [3];  // slope per temperature channel
  logic [7:0] min_q     [3];  // minimum duty per output
  logic [7:0] ton_q     [3];  // signed turn-on threshold per channel
  logic [7:0] acou_q;         // keep-minimum bits
  logic [7:0] cfgthr_q;       // shared pin choice
  logic [7:0] duty_d    [3];  // duty each output should show next
  logic [7:0] chan_duty [3];  // duty computed from each channel
  logic [2:0] chan_hot;       // channel sits above its threshold
  logic [2:0] chan_cold;      // channel below threshold minus hysteresis
  logic [7:0] temps     [3];
  logic [7:0] pwm_cnt_q;      // shared pwm ramp
  logic [15:0] tick_cnt_q;    // divider for the pwm ramp
  logic        tick_q;
  fpm_st_t    st_q      [3];
  logic [1:0] edges_q   [3];  // tach rising edges seen while spinning
  logic [2:0] tach_q;         // last tach level for edge detect
  logic [2:0] out_d;

  assign temps[0] = temp_rem1;
  assign temps[1] = temp_local;
  assign temps[2] = temp_rem2;

  // ----------------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------------
  // plain read-write registers; reset values fixed, writes by offset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 3; i++) begin
        cfg_q[i]  <= `FPM_RST_CFG;
        freq_q[i] <= `FPM_RST_FREQ;
        min_q[i]  <= `FPM_RST_MIN;
        ton_q[i]  <= `FPM_RST_TON;
      end
      acou_q   <= `FPM_RST_ACOU;
      cfgthr_q <= `FPM_RST_CFGTHR;
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        `FPM_A_CFG1:     cfg_q[0]  <= reg_req.wdata;
        `FPM_A_CFG2:     cfg_q[1]  <= reg_req.wdata;
        `FPM_A_CFG3:     cfg_q[2]  <= reg_req.wdata;
        `FPM_A_FREQ1:    freq_q[0] <= reg_req.wdata;
        `FPM_A_FREQ2:    freq_q[1] <= reg_req.wdata;
        `FPM_A_FREQ3:    freq_q[2] <= reg_req.wdata;
        `FPM_A_OUT1_KEEP_MINIMUM:     min_q[0]  <= reg_req.wdata;
        `FPM_A_OUT2_KEEP_MINIMUM:     min_q[1]  <= reg_req.wdata;
        `FPM_A_OUT3_KEEP_MINIMUM:     min_q[2]  <= reg_req.wdata;
        `FPM_A_TON1:     ton_q[0]  <= reg_req.wdata;
        `FPM_A_TON2:     ton_q[1]  <= reg_req.wdata;
        `FPM_A_TON3:     ton_q[2]  <= reg_req.wdata;
        `FPM_A_ACOU1:    acou_q    <= reg_req.wdata;
        `FPM_A_CFGTHREE: cfgthr_q  <= reg_req.wdata;
        default: ;  // duty and unmapped handled elsewhere or dropped
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // per channel automatic duty
  // ----------------------------------------------------------------------
  // duty = min + (temp - ton) * step, step from the slope code; a higher
  // slope code gives a smaller step. the step table is a coarse integer
  // approximation, chosen to keep the datapath to one small multiply.
  function automatic logic [7:0] slope_step(input logic [3:0] code);
    logic [7:0] s;
    s = 8'h01;
    unique case (code)
      4'h0: s = 8'h55;
      4'h1: s = 8'h44;
      4'h2: s = 8'h33;
      4'h3: s = 8'h2A;
      4'h4: s = 8'h22;
      4'h5: s = 8'h19;
      4'h6: s = 8'h15;
      4'h7: s = 8'h11;
      4'h8: s = 8'h0D;
      4'h9: s = 8'h0B;
      4'hA: s = 8'h08;
      4'hB: s = 8'h06;
      4'hC: s = 8'h05;
      4'hD: s = 8'h04;
      4'hE: s = 8'h03;
      4'hF: s = 8'h02;
    endcase
    return s;
  endfunction

  always_comb begin
    logic signed [8:0] diff;
    logic [16:0]       lin;
    diff = '0;
    lin  = '0;
    for (int c = 0; c < 3; c++) begin
      diff = $signed({temps[c][7], temps[c]}) -
             $signed({ton_q[c][7], ton_q[c]});
      chan_hot[c]  = diff > 9'sd0;
      chan_cold[c] = diff < -$signed({1'b0, `FPM_HYST_DEF});
      lin = 17'(diff[7:0]) *
            17'(slope_step(freq_q[c][`FPM_SLOPE_HI:`FPM_SLOPE_LO]));
      chan_duty[c] = `FPM_ZERO;
      if (chan_hot[c]) begin
        chan_duty[c] = (lin > 17'(`FPM_FULL)) ? `FPM_FULL : lin[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // behavior mux and applied duty
  // ----------------------------------------------------------------------
  always_comb begin
    logic [7:0] base;
    logic       hot;
    logic       cold;
    logic [7:0] run;
    fpm_bhv_t   b;
    base = `FPM_ZERO;
    hot  = 1'b0;
    cold = 1'b1;
    run  = `FPM_ZERO;
    b    = FPM_BHV_FULL;
    for (int o = 0; o < 3; o++) begin
      b    = fpm_bhv_t'(cfg_q[o][`FPM_BHV_HI:`FPM_BHV_LO]);
      unique case (b)
        FPM_BHV_REM1, FPM_BHV_LOCAL, FPM_BHV_REM2: begin
          base = chan_duty[int'(b)];
          hot  = chan_hot[int'(b)];
          cold = chan_cold[int'(b)];
        end
        FPM_BHV_MAX2: begin
          base = (chan_duty[1] > chan_duty[2]) ? chan_duty[1] : chan_duty[2];
          hot  = chan_hot[1] | chan_hot[2];
          cold = chan_cold[1] & chan_cold[2];
        end
        FPM_BHV_MAX3: begin
          base = (chan_duty[0] > chan_duty[1]) ? chan_duty[0] : chan_duty[1];
          base = (chan_duty[2] > base) ? chan_duty[2] : base;
          hot  = |chan_hot;
          cold = &chan_cold;
        end
        default: ;
      endcase
      run = (9'(base) + 9'(min_q[o]) > 9'(`FPM_FULL)) ? `FPM_FULL :
            8'(base + min_q[o]);
      duty_d[o] = duty_q[o];
      unique case (b)
        FPM_BHV_FULL:   duty_d[o] = `FPM_FULL;
        FPM_BHV_OFF:    duty_d[o] = `FPM_ZERO;
        FPM_BHV_MANUAL: begin
          if (reg_req.wr && reg_req.addr == `FPM_A_DUTY1 + 8'(o))
            duty_d[o] = reg_req.wdata;
        end
        default: begin
          unique case (st_q[o])
            FPM_ST_SPIN: duty_d[o] = `FPM_FULL;
            FPM_ST_RUN:  duty_d[o] = hot ? run : min_q[o];
            FPM_ST_IDLE: duty_d[o] = acou_q[`FPM_KEEP_LO + o] ?
                                     min_q[o] : `FPM_ZERO;
          endcase
          if (st_q[o] == FPM_ST_RUN && cold)
            duty_d[o] = acou_q[`FPM_KEEP_LO + o] ? min_q[o] : `FPM_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // automatic on/off state and spin-up
  // ----------------------------------------------------------------------
  // spin-up counts tach rising edges; a stalled fan stays at full drive,
  // which is the safe side for cooling.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int o = 0; o < 3; o++) begin
        st_q[o]    <= FPM_ST_IDLE;
        edges_q[o] <= 2'h0;
      end
      tach_q <= 3'h0;
    end else begin
      tach_q <= tach_in;
      for (int o = 0; o < 3; o++) begin
        logic hot_o;
        logic cold_o;
        logic [2:0] bo;
        bo     = cfg_q[o][`FPM_BHV_HI:`FPM_BHV_LO];
        hot_o  = 1'b0;
        cold_o = 1'b1;
        if (bo <= 3'h2) begin
          hot_o  = chan_hot[bo[1:0]];
          cold_o = chan_cold[bo[1:0]];
        end else if (bo == 3'h5) begin
          hot_o  = chan_hot[1] | chan_hot[2];
          cold_o = chan_cold[1] & chan_cold[2];
        end else if (bo == 3'h6) begin
          hot_o  = |chan_hot;
          cold_o = &chan_cold;
        end
        if (bo == 3'h3 || bo == 3'h4 || bo == 3'h7) begin
          st_q[o] <= FPM_ST_IDLE;  // non-auto modes reset the loop
        end else begin
          unique case (st_q[o])
            FPM_ST_IDLE: if (hot_o) begin
              st_q[o]    <= FPM_ST_SPIN;
              edges_q[o] <= 2'h0;
            end
            FPM_ST_SPIN: begin
              if (tach_in[o] && !tach_q[o])
                edges_q[o] <= edges_q[o] + 2'h1;
              if (edges_q[o] == `FPM_EDGES_NEED)
                st_q[o] <= FPM_ST_RUN;
            end
            FPM_ST_RUN: if (cold_o) st_q[o] <= FPM_ST_IDLE;
            default: st_q[o] <= FPM_ST_IDLE;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // applied duty registers
  // ----------------------------------------------------------------------
  // only manual mode takes a write, via duty_d
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int o = 0; o < 3; o++) duty_q[o] <= `FPM_RST_DUTY;
    end else begin
      for (int o = 0; o < 3; o++) duty_q[o] <= duty_d[o];
    end
  end

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= `FPM_ZERO;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        `FPM_A_DUTY1:    reg_rdata_q <= duty_q[0];
        `FPM_A_DUTY2:    reg_rdata_q <= duty_q[1];
        `FPM_A_DUTY3:    reg_rdata_q <= duty_q[2];
        `FPM_A_CFG1:     reg_rdata_q <= cfg_q[0];
        `FPM_A_CFG2:     reg_rdata_q <= cfg_q[1];
        `FPM_A_CFG3:     reg_rdata_q <= cfg_q[2];
        `FPM_A_FREQ1:    reg_rdata_q <= freq_q[0];
        `FPM_A_FREQ2:    reg_rdata_q <= freq_q[1];
        `FPM_A_FREQ3:    reg_rdata_q <= freq_q[2];
        `FPM_A_OUT1_KEEP_MINIMUM:     reg_rdata_q <= min_q[0];
        `FPM_A_OUT2_KEEP_MINIMUM:     reg_rdata_q <= min_q[1];
        `FPM_A_OUT3_KEEP_MINIMUM:     reg_rdata_q <= min_q[2];
        `FPM_A_TON1:     reg_rdata_q <= ton_q[0];
        `FPM_A_TON2:     reg_rdata_q <= ton_q[1];
        `FPM_A_TON3:     reg_rdata_q <= ton_q[2];
        `FPM_A_ACOU1:    reg_rdata_q <= acou_q;
        `FPM_A_CFGTHREE: reg_rdata_q <= cfgthr_q;
        default:         reg_rdata_q <= `FPM_ZERO;  // unmapped reads zero
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // pwm waveform and shared pin
  // ----------------------------------------------------------------------
  // slow tick from a divider; 256 ticks make one pwm period
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == `FPM_TICK_DIV);
      tick_cnt_q <= (tick_cnt_q == `FPM_TICK_DIV) ? 16'h0000 :
                    tick_cnt_q + 16'h0001;
    end
  end

  // compare ramp against eight bit duty
  always_comb begin
    for (int o = 0; o < 3; o++)
      out_d[o] = (duty_q[o] == `FPM_FULL) || (pwm_cnt_q < duty_q[o]);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pwm_cnt_q       <= 8'h00;
      fan_drive_out_q <= 3'h0;
      alert_out_q     <= 1'b0;
    end else begin
      if (tick_q) pwm_cnt_q <= pwm_cnt_q + 8'h01;
      fan_drive_out_q[0] <= out_d[0];
      fan_drive_out_q[2] <= out_d[2];
      // shared pin: second output or alert
      fan_drive_out_q[1] <= cfgthr_q[`FPM_PINSEL_BIT] ? 1'b0 : out_d[1];
      alert_out_q        <= cfgthr_q[`FPM_PINSEL_BIT] ? alert_req : 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: shared/fpm_defines.svh
/*
  register offsets, reset values and field positions of the fan drive mux.
  assumes a byte-wide register port driven by the serial interface logic.
*/
`ifndef FPM_DEFINES_SVH
`define FPM_DEFINES_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define FPM_A_DUTY1     8'h30
`define FPM_A_DUTY2     8'h31
`define FPM_A_DUTY3     8'h32
`define FPM_A_CFG1      8'h5C
`define FPM_A_CFG2      8'h5D
`define FPM_A_CFG3      8'h5E
`define FPM_A_FREQ1     8'h5F
`define FPM_A_FREQ2     8'h60
`define FPM_A_FREQ3     8'h61
`define FPM_A_ACOU1     8'h62
`define FPM_A_OUT1_KEEP_MINIMUM      8'h64
`define FPM_A_OUT2_KEEP_MINIMUM      8'h65
`define FPM_A_OUT3_KEEP_MINIMUM      8'h66
`define FPM_A_TON1      8'h67
`define FPM_A_TON2      8'h68
`define FPM_A_TON3      8'h69
`define FPM_A_CFGTHREE  8'h78
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FPM_RST_DUTY    8'hFF
`define FPM_RST_CFG     8'h62
`define FPM_RST_FREQ    8'hC4
`define FPM_RST_ACOU    8'h00
`define FPM_RST_MIN     8'h80
`define FPM_RST_TON     8'h5A
`define FPM_RST_CFGTHR  8'h00
`define FPM_FULL        8'hFF
`define FPM_ZERO        8'h00
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FPM_BHV_HI      7
`define FPM_BHV_LO      5
`define FPM_SLOPE_HI    7
`define FPM_SLOPE_LO    4
`define FPM_KEEP_LO     5
`define FPM_PINSEL_BIT  0
`define FPM_HYST_DEF    8'h04
`define FPM_EDGES_NEED  2'h2
`define FPM_TICK_DIV    16'h9C3F
`endif

// File: shared/fpm_pkg.sv
/*
  types of the fan drive mux: behavior codes and the register port bundle.
  assumes fpm_defines.svh is used alongside for the numbers.
*/
`default_nettype none
package fpm_pkg;
  // behavior selector codes
  typedef enum logic [2:0] {
    FPM_BHV_REM1   = 3'h0,
    FPM_BHV_LOCAL  = 3'h1,
    FPM_BHV_REM2   = 3'h2,
    FPM_BHV_FULL   = 3'h3,
    FPM_BHV_OFF    = 3'h4,
    FPM_BHV_MAX2   = 3'h5,
    FPM_BHV_MAX3   = 3'h6,
    FPM_BHV_MANUAL = 3'h7
  } fpm_bhv_t;
  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fpm_req_t;
  // per-output auto control state
  typedef enum logic [1:0] {FPM_ST_IDLE, FPM_ST_SPIN, FPM_ST_RUN} fpm_st_t;
endpackage
`default_nettype wire

// File: verification/fpm_fan_model.sv
/*
  fan model: drive transistor plus tach sensor for each of three outputs.
  assumes a high drive powers the fan; the tach only moves while powered.
*/
`default_nettype none
module fpm_fan_model #(
  parameter int HALF = 20 // tach half period in cycles, fast fan
) (
  input  wire logic       clk_sys,
  input  wire logic [2:0] drive,
  input  wire logic       slow,
  output var  logic [2:0] tach
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // rotation counters
  // ----------------------------------------------------------------
  int cnt_q [3]; // cycles since last tach toggle
  initial tach = 3'h0;
  // tach edges only while the fan is powered
  // an unpowered fan stalls, so its tach level just freezes
  always @(posedge clk_sys) begin
    for (int i = 0; i < 3; i++) begin
      if (!drive[i]) begin
        cnt_q[i] <= 0;
      end else if (cnt_q[i] >= (slow ? 10 * HALF : HALF)) begin
        cnt_q[i] <= 0;
        tach[i]  <= ~tach[i];
      end else begin
        cnt_q[i] <= cnt_q[i] + 1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/fpm_top_chk.sv
/*
  checker of the fan drive mux, watching only the top module's ports.
  assumes register writes land on the edge that takes them.
*/
`include "fpm_defines.svh"
`default_nettype none
module fpm_top_chk
  import fpm_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire fpm_req_t   reg_req,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       alert_req,
  input wire logic [2:0] fan_drive_out_q,
  input wire logic       alert_out_q
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // register shadows
  // ----------------------------------------------------------------
  fpm_bhv_t   bhv_q; // output one behavior
  logic [7:0] man_q; // output one software duty, 5A means unknown
  logic       sel_q; // shared pin select
  // follow the writes that matter to the properties
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bhv_q <= FPM_BHV_FULL;
      man_q <= 8'h5A;
      sel_q <= 1'b0;
    end else if (reg_req.wr) begin
      if (reg_req.addr == `FPM_A_CFG1) begin
        bhv_q <= fpm_bhv_t'(reg_req.wdata[7:5]);
        man_q <= 8'h5A;
      end else if (reg_req.addr == `FPM_A_DUTY1 &&
                   bhv_q == FPM_BHV_MANUAL) begin
        man_q <= reg_req.wdata;
      end else if (reg_req.addr == `FPM_A_CFGTHREE) begin
        sel_q <= reg_req.wdata[0];
      end
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // mode sequences, three cycles cover register plus output stage
  // ----------------------------------------------------------------
  sequence s_full;
    (bhv_q == FPM_BHV_FULL) [*3];
  endsequence
  sequence s_man(logic [7:0] v);
    (bhv_q == FPM_BHV_MANUAL && man_q == v) [*3];
  endsequence
  property p_full;
    s_full |-> fan_drive_out_q[0];
  endproperty
  a_full: assert property (p_full)
    else $error("full mode not high");
  property p_off;
    (bhv_q == FPM_BHV_OFF) [*3] |-> !fan_drive_out_q[0];
  endproperty
  a_off: assert property (p_off)
    else $error("disabled output drives");
  property p_man_low;
    s_man(8'h00) |-> !fan_drive_out_q[0];
  endproperty
  a_man_low: assert property (p_man_low)
    else $error("zero duty drives");
  property p_man_high;
    s_man(8'hFF) |-> fan_drive_out_q[0];
  endproperty
  a_man_high: assert property (p_man_high)
    else $error("full duty low");
  property p_rd_full;
    s_full ##0 (reg_req.rd && reg_req.addr == `FPM_A_DUTY1)
      |=> reg_rdata_q == 8'hFF;
  endproperty
  a_rd_full: assert property (p_rd_full)
    else $error("duty read wrong");
  property p_pin_drive;
    $past(sel_q) |-> !fan_drive_out_q[1];
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("pin still pwm");
  property p_alert_off;
    !$past(sel_q) |-> !alert_out_q;
  endproperty
  a_alert_off: assert property (p_alert_off)
    else $error("alert leaks");
  property p_alert_pass;
    $past(sel_q) |-> alert_out_q == $past(alert_req);
  endproperty
  a_alert_pass: assert property (p_alert_pass)
    else $error("alert lost");
endmodule
bind fpm_top fpm_top_chk chk_u (
  .clk_sys        (clk_sys),
  .resetn         (resetn),
  .reg_req        (reg_req),
  .reg_rdata_q    (reg_rdata_q),
  .alert_req      (alert_req),
  .fan_drive_out_q(fan_drive_out_q),
  .alert_out_q    (alert_out_q)
);
`default_nettype wire

// File: verification/fpm_top_tb_top.sv
/*
  self-checking bench of the fan drive mux with a fan model on the pins.
  assumes the register port and temperatures are driven 1 ns past edges.
*/
`default_nettype none
module fpm_top_tb_top
  import fpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // wiring
  // ----------------------------------------------------------------
  logic       clk_sys, resetn, alert_req, slow, alert_out_q;
  fpm_req_t   reg_req;
  logic [7:0] reg_rdata_q, temp_rem1, temp_local, temp_rem2, d;
  logic [2:0] tach_in, fan_drive_out_q;
  int         n_mismatch = 0, samples_checked = 0;
  fpm_top dut_u (.clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req),
    .reg_rdata_q(reg_rdata_q), .temp_rem1(temp_rem1),
    .temp_local(temp_local), .temp_rem2(temp_rem2), .tach_in(tach_in),
    .alert_req(alert_req), .fan_drive_out_q(fan_drive_out_q),
    .alert_out_q(alert_out_q));
  fpm_fan_model fan_u (.clk_sys(clk_sys), .drive(fan_drive_out_q),
    .slow(slow), .tach(tach_in));
  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------
  // port tasks and comparisons
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // one-cycle pulses; the idle edge between calls avoids double drives
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    cyc(1);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    cyc(1);
    reg_req.wr = 1'b0;
  endtask
  // read without judging; the caller decides what the byte must be
  task automatic rd_byte(input logic [7:0] a);
    cyc(1);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    cyc(1);
    reg_req.rd = 1'b0;
    d = reg_rdata_q;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd_byte(a);
    chk8(d, e);
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: byte %h not %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: flag %b not %b", $time, g, e);
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 3; i++) begin
      rc(8'h30 + 8'(i), 8'hFF);
      rc(8'h67 + 8'(i), 8'h5A);
      rc(8'h64 + 8'(i), 8'h80);
      rc(8'h5C + 8'(i), 8'h62);
    end
    rc(8'h78, 8'h00);
    chk8({5'h00, fan_drive_out_q}, 8'h07);
    $display("t_reset done");
  endtask
  task automatic t_manual();
    wr(8'h5C, 8'hE0);
    wr(8'h30, 8'h40);
    rc(8'h30, 8'h40);
    wr(8'h30, 8'h00);
    cyc(4);
    chk1(fan_drive_out_q[0], 1'b0);
    wr(8'h30, 8'hFF);
    cyc(4);
    chk1(fan_drive_out_q[0], 1'b1);
    wr(8'h5C, 8'h82);
    cyc(4);
    chk1(fan_drive_out_q[0], 1'b0);
    wr(8'h5C, 8'h62);
    wr(8'h30, 8'h12);
    rc(8'h30, 8'hFF);
    $display("t_manual done");
  endtask
  task automatic t_pin();
    alert_req = 1'b1;
    wr(8'h78, 8'h01);
    cyc(3);
    chk1(alert_out_q, 1'b1);
    chk1(fan_drive_out_q[1], 1'b0);
    alert_req = 1'b0;
    cyc(2);
    chk1(alert_out_q, 1'b0);
    wr(8'h78, 8'h00);
    alert_req = 1'b1;
    cyc(3);
    chk1(alert_out_q, 1'b0);
    chk1(fan_drive_out_q[1], 1'b1);
    alert_req = 1'b0;
    $display("t_pin done");
  endtask
  // cold loop on outputs one and two, keep bits 5 and 6
  task automatic t_keep();
    wr(8'h5C, 8'h22);
    wr(8'h5D, 8'h22);
    rc(8'h30, 8'h00);
    // an idle auto output must not take a software duty
    wr(8'h30, 8'h12);
    rc(8'h30, 8'h00);
    wr(8'h62, 8'h60);
    rc(8'h30, 8'h80);
    rc(8'h31, 8'h80);
    wr(8'h62, 8'h00);
    wr(8'h5C, 8'h62);
    wr(8'h5D, 8'h62);
    $display("t_keep done");
  endtask
  // output three on local channel, slow fan, through every loop state
  task automatic t_auto();
    wr(8'h68, 8'hF6);
    rc(8'h68, 8'hF6);
    wr(8'h68, 8'h28);
    wr(8'h5E, 8'h22);
    rc(8'h32, 8'h00);
    slow = 1'b1;
    temp_local = 8'h29;
    // one edge to leave idle, one more for the duty register
    cyc(2);
    rc(8'h32, 8'hFF);
    // slow fan has given no tach edge yet, so still spinning
    cyc(150);
    rc(8'h32, 8'hFF);
    cyc(900);
    rd_byte(8'h32);
    chk1(d inside {[8'h80:8'hFE]}, 1'b1);
    // steep slope saturates eight degrees up, shallow one does not
    temp_local = 8'h30;
    wr(8'h60, 8'h04);
    rc(8'h32, 8'hFF);
    wr(8'h60, 8'hF4);
    rd_byte(8'h32);
    chk1(d inside {[8'h81:8'hFE]}, 1'b1);
    wr(8'h60, 8'hC4);
    temp_local = 8'h7F;
    rc(8'h32, 8'hFF);
    temp_local = 8'h28;
    rc(8'h32, 8'h80);
    temp_local = 8'h24;
    rc(8'h32, 8'h80);
    temp_local = 8'h23;
    rc(8'h32, 8'h00);
    wr(8'h62, 8'h80);
    rc(8'h32, 8'h80);
    wr(8'h62, 8'h00);
    temp_local = 8'h14;
    slow = 1'b0;
    $display("t_auto done");
  endtask
  // each channel mux code against each hot channel
  task automatic t_mux();
    logic [2:0] code [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    logic [2:0] hot [5] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
    wr(8'h67, 8'h28);
    wr(8'h69, 8'h28);
    for (int c = 0; c < 5; c++) begin
      wr(8'h5E, {code[c], 5'h02});
      for (int h = 0; h < 3; h++) begin
        temp_rem1  = (h == 0) ? 8'h3C : 8'h14;
        temp_local = (h == 1) ? 8'h3C : 8'h14;
        temp_rem2  = (h == 2) ? 8'h3C : 8'h14;
        cyc(300);
        rd_byte(8'h32);
        chk1(d !== 8'h00, hot[c][h]);
        temp_rem1  = 8'h14;
        temp_local = 8'h14;
        temp_rem2  = 8'h14;
        cyc(4);
      end
    end
    $display("t_mux done");
  endtask
  task automatic summarize();
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    reg_req = '0;
    resetn = 1'b0;
    alert_req = 1'b0;
    slow = 1'b0;
    temp_rem1 = 8'h14;
    temp_local = 8'h14;
    temp_rem2 = 8'h14;
    cyc(6);
    resetn = 1'b1;
    t_reset();
    t_manual();
    t_pin();
    t_keep();
    t_auto();
    t_mux();
    summarize();
  end
  // the tests need about 5800 cycles; allow more than three times that
  initial begin
    #(25 * 21000);
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
